// ---- design/voltage_sync_check_map.svh ----
// constants for the synchronism check block: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design file
`ifndef VOLTAGE_SYNC_CHECK_MAP_SVH
`define VOLTAGE_SYNC_CHECK_MAP_SVH
// register word offsets (byte address = 4 * index)
`define REG_CTRL 4'h0
`define REG_LIMIT_MAG 4'h1
`define REG_LIMIT_ANG 4'h2
`define REG_LIMIT_FREQ 4'h3
`define REG_THRESH 4'h4
`define REG_BRK_TIME 4'h5
`define REG_STATUS 4'h6
`define REG_MAG_DIFF 4'h7
`define REG_ANG_DIFF 4'h8
`define REG_FREQ_DIFF 4'h9
`define REG_ROTATE 4'hA
`define REG_CLOSE_EST 4'hB
`define REG_PLACE 4'hC
// control fields
`define CTRL_ENABLE 0
`define CTRL_START_ON 1
`define CTRL_PTC 2
`define CTRL_REF_LO 3
`define CTRL_REF_HI 4
`define CTRL_SEL_LO 5
`define CTRL_SEL_HI 6
`define CTRL_COND_LO 8
`define CTRL_COND_HI 11
// threshold fields: live in low half, dead in high half
`define THR_LIVE_HI 15
`define THR_DEAD_LO 16
// reset values
`define CTRL_RST 32'h0000_0F20
`define LIM_MAG_RST 16'h01F4
`define LIM_ANG_RST 16'h03E8
`define LIM_FREQ_RST 16'h0064
`define LIVE_RST 16'h1F40
`define DEAD_RST 16'h07D0
`define BRK_RST 16'h000A
// timing: program cycle 5 ms at 25 MHz
`define CYCLE_MS 5
`define CLK_KHZ 25000
`define CYCLE_CLKS (`CYCLE_MS * `CLK_KHZ)
// 5 ms steps per full turn: (1000 / df_mhz) s / 0.005 s = 200000 / df_mhz
`define TURN_NUM 32'h0003_0D40
`define NOM_RATE_CONST 32'h0000_0005
`endif

// ---- design/voltage_sync_check_pkg.sv ----
// types shared by the synchronism check block
// assumes the map header sits beside it
`include "voltage_sync_check_map.svh"
package voltage_sync_check_pkg;
  typedef enum logic [2:0] {
    COND_BLOCKED = 3'b000,
    COND_OK = 3'b001,
    COND_BYPASS = 3'b010,
    COND_VCOND_OK = 3'b011,
    COND_MAG_OK = 3'b100,
    COND_ANG_OK = 3'b101,
    COND_FREQ_OK = 3'b110
  } cond_code_t;
  typedef enum logic [2:0] {
    VS_DEAD_DEAD = 3'b000,
    VS_LIVE_DEAD = 3'b001,
    VS_DEAD_LIVE = 3'b010,
    VS_LIVE_LIVE = 3'b011,
    VS_UNDEFINED = 3'b100,
    VS_NOT_MON = 3'b101
  } volt_state_t;
  typedef enum logic [1:0] {
    SW_STILL = 2'b00,
    SW_DEPART = 2'b01,
    SW_ENCLOSE = 2'b10
  } switch_state_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;
endpackage : voltage_sync_check_pkg

// ---- design/voltage_sync_check.sv ----
// synchronism check stage: compares a selected channel against a reference
// assumes channel words settle with their refresh strobe, Avalon-MM master
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "voltage_sync_check_map.svh"
module voltage_sync_check
  import voltage_sync_check_pkg::*;
  #(parameter int unsigned CYCLE_LEN = `CYCLE_CLKS) // clocks per program cycle
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] channel_one_fundamental,
  input wire logic [15:0] channel_two_fundamental,
  input wire logic [15:0] channel_three_fundamental,
  input wire logic [15:0] channel_four_fundamental,
  input wire logic [15:0] channel_one_angle,
  input wire logic [15:0] channel_two_angle,
  input wire logic [15:0] channel_three_angle,
  input wire logic [15:0] channel_four_angle,
  input wire logic [15:0] channel_one_freq,
  input wire logic [15:0] channel_two_freq,
  input wire logic [15:0] channel_three_freq,
  input wire logic [15:0] channel_four_freq,
  input wire logic block_input,
  input wire logic stage_start_input,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic match_ok_output,
  output logic inhibited_output,
  output logic close_command,
  output logic cycle_tick
);

  // program cycle counter: one tick every 5 ms
  logic [31:0] cyc_cnt_r, cyc_cnt_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    tick_nxt = 1'b0;
    cyc_cnt_nxt = cyc_cnt_r + 32'h0000_0001;
    if (cyc_cnt_r == 32'(CYCLE_LEN - 1)) begin
      cyc_cnt_nxt = 32'h0000_0000;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cyc_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      cyc_cnt_r <= cyc_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // configuration registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] lim_mag_r, lim_mag_nxt, lim_ang_r, lim_ang_nxt, lim_frq_r, lim_frq_nxt;
  logic [15:0] live_r, live_nxt, dead_r, dead_nxt, brk_r, brk_nxt;
  logic [31:0] wmask;
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    ctrl_nxt = ctrl_r;
    lim_mag_nxt = lim_mag_r;
    lim_ang_nxt = lim_ang_r;
    lim_frq_nxt = lim_frq_r;
    live_nxt = live_r;
    dead_nxt = dead_r;
    brk_nxt = brk_r;
    if (avs_write && avs_waitrequest == 1'b0) begin
      case (avs_address)
        `REG_CTRL: ctrl_nxt = (ctrl_r & ~wmask) | (avs_writedata & wmask);
        `REG_LIMIT_MAG: lim_mag_nxt = (lim_mag_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        `REG_LIMIT_ANG: lim_ang_nxt = (lim_ang_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        `REG_LIMIT_FREQ: lim_frq_nxt = (lim_frq_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        `REG_THRESH: begin
          live_nxt = (live_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
          dead_nxt = (dead_r & ~wmask[31:16]) | (avs_writedata[31:16] & wmask[31:16]);
        end
        `REG_BRK_TIME: brk_nxt = (brk_r & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      lim_mag_r <= `LIM_MAG_RST;
      lim_ang_r <= `LIM_ANG_RST;
      lim_frq_r <= `LIM_FREQ_RST;
      live_r <= `LIVE_RST;
      dead_r <= `DEAD_RST;
      brk_r <= `BRK_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      lim_mag_r <= lim_mag_nxt;
      lim_ang_r <= lim_ang_nxt;
      lim_frq_r <= lim_frq_nxt;
      live_r <= live_nxt;
      dead_r <= dead_nxt;
      brk_r <= brk_nxt;
    end
  end

  // channel selection: reference and compared channel by index
  logic [15:0] mag_a, mag_b, ang_a, ang_b, frq_a, frq_b;
  function automatic logic [15:0] pick(input logic [1:0] idx, input logic [15:0] c0,
      input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] c3);
    case (idx)
      2'b00: pick = c0;
      2'b01: pick = c1;
      2'b10: pick = c2;
      default: pick = c3;
    endcase
  endfunction : pick
  always_comb begin
    // both selected channels observed
    mag_a = pick(ctrl_r[`CTRL_REF_HI:`CTRL_REF_LO], channel_one_fundamental,
                 channel_two_fundamental, channel_three_fundamental, channel_four_fundamental);
    mag_b = pick(ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO], channel_one_fundamental,
                 channel_two_fundamental, channel_three_fundamental, channel_four_fundamental);
    ang_a = pick(ctrl_r[`CTRL_REF_HI:`CTRL_REF_LO], channel_one_angle,
                 channel_two_angle, channel_three_angle, channel_four_angle);
    ang_b = pick(ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO], channel_one_angle,
                 channel_two_angle, channel_three_angle, channel_four_angle);
    frq_a = pick(ctrl_r[`CTRL_REF_HI:`CTRL_REF_LO], channel_one_freq,
                 channel_two_freq, channel_three_freq, channel_four_freq);
    frq_b = pick(ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO], channel_one_freq,
                 channel_two_freq, channel_three_freq, channel_four_freq);
  end

  // per-cycle measurement, comparison and decision state
  logic signed [16:0] mag_d_r, mag_d_nxt, ang_d_r, ang_d_nxt, frq_d_r, frq_d_nxt;
  volt_state_t vs_r, vs_nxt;
  cond_code_t cond_r, cond_nxt;
  switch_state_t sw_r, sw_nxt;
  logic blk_r, blk_nxt, ok_r, ok_nxt, inh_r, inh_nxt, sync_r, sync_nxt, cls_r, cls_nxt;
  logic [15:0] rot_r, rot_nxt, est_r, est_nxt;
  logic [31:0] place_r, place_nxt;
  logic a_live, a_dead, b_live, b_dead, mag_in, ang_in, frq_in, vcond_in, active;
  logic [16:0] mag_abs, ang_abs, frq_abs;
  logic [16:0] prev_ang_abs_r, prev_ang_abs_nxt;
  logic [31:0] rot_wide, est_wide;
  always_comb begin
    mag_d_nxt = mag_d_r;
    ang_d_nxt = ang_d_r;
    frq_d_nxt = frq_d_r;
    vs_nxt = vs_r;
    cond_nxt = cond_r;
    sw_nxt = sw_r;
    blk_nxt = blk_r;
    ok_nxt = ok_r;
    inh_nxt = inh_r;
    sync_nxt = sync_r;
    cls_nxt = 1'b0;
    rot_nxt = rot_r;
    est_nxt = est_r;
    place_nxt = place_r;
    prev_ang_abs_nxt = prev_ang_abs_r;
    a_live = mag_a > live_r;
    a_dead = mag_a < dead_r;
    b_live = mag_b > live_r;
    b_dead = mag_b < dead_r;
    mag_abs = mag_d_r[16] ? 17'(-mag_d_r) : 17'(mag_d_r);
    ang_abs = ang_d_r[16] ? 17'(-ang_d_r) : 17'(ang_d_r);
    frq_abs = frq_d_r[16] ? 17'(-frq_d_r) : 17'(frq_d_r);
    mag_in = mag_abs <= {1'b0, lim_mag_r};
    ang_in = ang_abs <= {1'b0, lim_ang_r};
    frq_in = frq_abs <= {1'b0, lim_frq_r};
    // condition bits: dd, ld, dl, ll accepted combinations
    case (vs_r)
      VS_DEAD_DEAD: vcond_in = ctrl_r[`CTRL_COND_LO];
      VS_LIVE_DEAD: vcond_in = ctrl_r[`CTRL_COND_LO + 1];
      VS_DEAD_LIVE: vcond_in = ctrl_r[`CTRL_COND_LO + 2];
      VS_LIVE_LIVE: vcond_in = ctrl_r[`CTRL_COND_HI];
      default: vcond_in = 1'b0;
    endcase
    active = ctrl_r[`CTRL_ENABLE] &&
             (!ctrl_r[`CTRL_START_ON] || stage_start_input);
    frq_abs = frq_abs == 17'h0_0000 ? 17'h0_0001 : frq_abs;
    rot_wide = `TURN_NUM / {15'h0000, frq_abs};
    est_wide = (32'(ang_abs) * 32'(rot_r)) / 32'h0000_8CA0;
    if (tick_r) begin
      blk_nxt = block_input;
      mag_d_nxt = $signed({1'b0, mag_b}) - $signed({1'b0, mag_a});
      ang_d_nxt = $signed({1'b0, ang_b}) - $signed({1'b0, ang_a});
      frq_d_nxt = $signed({1'b0, frq_b}) - $signed({1'b0, frq_a});
      place_nxt = 32'(ang_d_r) * `NOM_RATE_CONST * 32'h0000_0002;
      prev_ang_abs_nxt = ang_abs;
      if (!ctrl_r[`CTRL_ENABLE]) begin
        vs_nxt = VS_NOT_MON;
      end else if ((a_live || a_dead) && (b_live || b_dead)) begin
        vs_nxt = volt_state_t'({1'b0, b_live, a_live});
      end else begin
        vs_nxt = VS_UNDEFINED;
      end
      rot_nxt = rot_wide[31:16] != 16'h0000 ? 16'hFFFF : rot_wide[15:0];
      est_nxt = est_wide[31:16] != 16'h0000 ? 16'hFFFF : est_wide[15:0];
      if (ctrl_r[`CTRL_PTC]) begin
        if (ang_abs < prev_ang_abs_r) begin
          sw_nxt = SW_ENCLOSE;
        end else if (ang_abs > prev_ang_abs_r) begin
          sw_nxt = SW_DEPART;
        end else begin
          sw_nxt = SW_STILL;
        end
      end else begin
        sw_nxt = SW_STILL;
      end
      sync_nxt = active && mag_in && ang_in && frq_in && vcond_in;
      if (sync_nxt && !sync_r && block_input) begin
        inh_nxt = 1'b1;
      end else if (!sync_nxt) begin
        inh_nxt = 1'b0;
      end
      ok_nxt = sync_nxt && !block_input && !inh_nxt;
      cls_nxt = ok_nxt && ctrl_r[`CTRL_PTC] && sw_r == SW_ENCLOSE &&
                est_r <= brk_r;
      if (!ctrl_r[`CTRL_ENABLE]) begin
        cond_nxt = COND_BYPASS;
      end else if (block_input) begin
        cond_nxt = COND_BLOCKED;
      end else if (ok_nxt) begin
        cond_nxt = COND_OK;
      end else if (!vcond_in) begin
        cond_nxt = COND_VCOND_OK;
      end else if (!mag_in) begin
        cond_nxt = COND_MAG_OK;
      end else if (!ang_in) begin
        cond_nxt = COND_ANG_OK;
      end else begin
        cond_nxt = COND_FREQ_OK;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mag_d_r <= 17'h0_0000;
      ang_d_r <= 17'h0_0000;
      frq_d_r <= 17'h0_0000;
      vs_r <= VS_NOT_MON;
      cond_r <= COND_BYPASS;
      sw_r <= SW_STILL;
      blk_r <= 1'b0;
      ok_r <= 1'b0;
      inh_r <= 1'b0;
      sync_r <= 1'b0;
      cls_r <= 1'b0;
      rot_r <= 16'h0000;
      est_r <= 16'h0000;
      place_r <= 32'h0000_0000;
      prev_ang_abs_r <= 17'h0_0000;
    end else begin
      mag_d_r <= mag_d_nxt;
      ang_d_r <= ang_d_nxt;
      frq_d_r <= frq_d_nxt;
      vs_r <= vs_nxt;
      cond_r <= cond_nxt;
      sw_r <= sw_nxt;
      blk_r <= blk_nxt;
      ok_r <= ok_nxt;
      inh_r <= inh_nxt;
      sync_r <= sync_nxt;
      cls_r <= cls_nxt;
      rot_r <= rot_nxt;
      est_r <= est_nxt;
      place_r <= place_nxt;
      prev_ang_abs_r <= prev_ang_abs_nxt;
    end
  end

  // bus slave: one wait cycle, then answer; waitrequest registered, high when idle
  bus_state_t bus_r, bus_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic wait_r, wait_nxt;
  always_comb begin
    bus_nxt = BUS_IDLE;
    rd_nxt = rd_r;
    wait_nxt = 1'b1;
    if (bus_r == BUS_IDLE && (avs_read || avs_write)) begin
      bus_nxt = BUS_ANSWER;
      wait_nxt = 1'b0;
      case (avs_address)
        `REG_CTRL: rd_nxt = ctrl_r;
        `REG_LIMIT_MAG: rd_nxt = {16'h0000, lim_mag_r};
        `REG_LIMIT_ANG: rd_nxt = {16'h0000, lim_ang_r};
        `REG_LIMIT_FREQ: rd_nxt = {16'h0000, lim_frq_r};
        `REG_THRESH: rd_nxt = {dead_r, live_r};
        `REG_BRK_TIME: rd_nxt = {16'h0000, brk_r};
        `REG_STATUS: rd_nxt = {16'h0000, 4'h0, inh_r, ok_r, blk_r, sw_r, vs_r, cond_r};
        `REG_MAG_DIFF: rd_nxt = 32'(mag_d_r);
        `REG_ANG_DIFF: rd_nxt = 32'(ang_d_r);
        `REG_FREQ_DIFF: rd_nxt = 32'(frq_d_r);
        `REG_ROTATE: rd_nxt = {16'h0000, rot_r};
        `REG_CLOSE_EST: rd_nxt = {16'h0000, est_r};
        `REG_PLACE: rd_nxt = place_r;
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_r <= BUS_IDLE;
      rd_r <= 32'h0000_0000;
      wait_r <= 1'b1;
    end else begin
      bus_r <= bus_nxt;
      rd_r <= rd_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign avs_readdata = rd_r;
  assign avs_waitrequest = wait_r;
  assign match_ok_output = ok_r;
  assign inhibited_output = inh_r;
  assign close_command = cls_r;
  assign cycle_tick = tick_r;
endmodule : voltage_sync_check
`default_nettype wire

// ---- tb/voltage_sync_check_asserts.sv ----
// checker for the synchronism check block, bound to its top module
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "voltage_sync_check_map.svh"
module voltage_sync_check_asserts #(
  parameter int unsigned CYCLE_LEN = `CYCLE_CLKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic block_input,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic match_ok_output,
  input wire logic inhibited_output,
  input wire logic close_command,
  input wire logic cycle_tick
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [16:0] gap_r;
  logic [16:0] gap_nxt;
  logic blk_r;
  logic blk_nxt;
  // clocks since last tick, all ones until the first; blocking seen at tick
  always_comb begin
    gap_nxt = cycle_tick ? 17'h0_0000 : gap_r + {16'h0000, gap_r != 17'h1_FFFF};
    blk_nxt = cycle_tick ? block_input : blk_r;
  end
  always_ff @(posedge clk_sys) begin
    gap_r <= rst_n ? gap_nxt : 17'h1_FFFF;
    blk_r <= rst_n & blk_nxt;
  end
  sequence req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answered;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  tick_period_a: assert property (cycle_tick && gap_r != 17'h1_FFFF |-> gap_r == 17'(CYCLE_LEN - 1))
    else $error("program cycle spacing wrong");
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> req_seen ##1 answered)
    else $error("bus answer not after one wait cycle");
  ok_sample_a: assert property ($changed(match_ok_output) |-> $past(cycle_tick) || $past(cycle_tick, 2))
    else $error("match output moved off the cycle start");
  inh_sample_a: assert property ($changed(inhibited_output) |-> $past(cycle_tick) || $past(cycle_tick, 2))
    else $error("inhibit output moved off the cycle start");
  ok_rise_a: assert property ($rose(match_ok_output) |-> !blk_r)
    else $error("match raised while blocked");
  inh_rise_a: assert property ($rose(inhibited_output) |-> blk_r)
    else $error("inhibit raised without blocking");
  ok_excl_a: assert property (inhibited_output |-> !match_ok_output)
    else $error("match and inhibit together");
  block_drop_a: assert property (blk_r && $past(blk_r, 2) |-> !match_ok_output)
    else $error("match held under blocking");
  close_tick_a: assert property ($changed(close_command) |-> $past(cycle_tick) || $past(cycle_tick, 2))
    else $error("close command moved off the cycle start");
endmodule : voltage_sync_check_asserts
bind voltage_sync_check voltage_sync_check_asserts #(.CYCLE_LEN(CYCLE_LEN)) chk (
  .clk_sys(clk_sys), .rst_n(rst_n),
  .block_input(block_input), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .match_ok_output(match_ok_output),
  .inhibited_output(inhibited_output), .close_command(close_command), .cycle_tick(cycle_tick));
`default_nettype wire

// ---- tb/grid_model.sv ----
// far-side model: voltage channel front end refreshed each program cycle
// assumes the bench sets target words and the block's tick marks the refresh
`timescale 1ns/1ps
`default_nettype none
module grid_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic refresh,
  input wire logic [2:0][15:0] ref_set,
  input wire logic [2:0][15:0] cmp_set,
  output logic [3:0][15:0] mag,
  output logic [3:0][15:0] ang,
  output logic [3:0][15:0] frq
);
  // new words only at refresh; spare channels wander every refresh
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mag <= '0;
      ang <= '0;
      frq <= '0;
    end else if (refresh) begin
      mag[1:0] <= {cmp_set[0], ref_set[0]};
      ang[1:0] <= {cmp_set[1], ref_set[1]};
      frq[1:0] <= {cmp_set[2], ref_set[2]};
      mag[3:2] <= {~mag[2], mag[2] + 16'h0101};
      ang[3:2] <= {mag[2], mag[3]};
      frq[3:2] <= {mag[2] ^ 16'h00FF, ~mag[3]};
    end
  end
endmodule : grid_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the synchronism check block
// assumes package, checker and channel model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "voltage_sync_check_map.svh"
module testbench
  import voltage_sync_check_pkg::*;
;
  typedef struct {logic [31:0] v; logic [31:0] m; string n;} note_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic block_input = 1'b0;
  logic stage_start_input = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [2:0][15:0] ref_set = '0;
  logic [2:0][15:0] cmp_set = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, match_ok_output, inhibited_output, close_command, cycle_tick;
  logic [3:0][15:0] mag, ang, frq;
  logic [15:0] r, a, f;
  note_t notes[$];
  note_t nt;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int closes = 0;
  always #20 clk_sys = ~clk_sys;
  // short program cycle keeps the run brief
  voltage_sync_check #(.CYCLE_LEN(32'h0000_03E8)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .channel_one_fundamental(mag[0]), .channel_two_fundamental(mag[1]),
    .channel_three_fundamental(mag[2]), .channel_four_fundamental(mag[3]),
    .channel_one_angle(ang[0]), .channel_two_angle(ang[1]),
    .channel_three_angle(ang[2]), .channel_four_angle(ang[3]),
    .channel_one_freq(frq[0]), .channel_two_freq(frq[1]),
    .channel_three_freq(frq[2]), .channel_four_freq(frq[3]),
    .block_input(block_input), .stage_start_input(stage_start_input),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .match_ok_output(match_ok_output), .inhibited_output(inhibited_output),
    .close_command(close_command), .cycle_tick(cycle_tick));
  grid_model far (.clk_sys(clk_sys), .rst_n(rst_n), .refresh(cycle_tick),
    .ref_set(ref_set), .cmp_set(cmp_set), .mag(mag), .ang(ang), .frq(frq));
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= ad;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] ad, input logic [31:0] v, input logic [31:0] m,
                    input string n);
    notes.push_back('{v & m, m, n});
    bus(1'b0, ad, 32'h0000_0000);
  endtask : rd
  // new channel targets, then three program cycles to reach the outputs
  task automatic setv(input logic [15:0] rm, input logic [15:0] cm, input logic blk,
                      input logic st);
    @(posedge clk_sys);
    ref_set <= {16'hC350, 16'h1388, rm};
    cmp_set <= {16'hC350 + f, 16'h1388 + a, cm};
    block_input <= blk;
    stage_start_input <= st;
    repeat (3) begin
      @(posedge clk_sys);
      while (cycle_tick !== 1'b1) @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask : setv
  // compare each read answer with the oldest note
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      nt = notes.pop_front();
      check(nt.n, avs_readdata & nt.m, nt.v);
    end
  end
  // count close pulses seen
  always @(posedge clk_sys) begin
    if (close_command === 1'b1) closes++;
  end
  // cut a hang short, about twice the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 32'h0000_EA60) begin
      fails++;
      close_out();
    end
  end
  // main sequence
  initial begin
    void'($urandom(59470));
    r = 16'($urandom_range(400, 0));
    a = 16'($urandom_range(900, 2)); // at least 2 so halving encloses
    f = 16'($urandom_range(90, 4)); // at least 4 so rotation fits 16 bits
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`REG_CTRL, `CTRL_RST, '1, "ctrl reset");
    rd(`REG_LIMIT_MAG, {16'h0000, `LIM_MAG_RST}, '1, "mag limit reset");
    rd(`REG_LIMIT_ANG, {16'h0000, `LIM_ANG_RST}, '1, "angle limit reset");
    rd(`REG_LIMIT_FREQ, {16'h0000, `LIM_FREQ_RST}, '1, "freq limit reset");
    rd(`REG_THRESH, {`DEAD_RST, `LIVE_RST}, '1, "threshold reset");
    rd(`REG_BRK_TIME, {16'h0000, `BRK_RST}, '1, "breaker time reset");
    bus(1'b1, 4'hF, $urandom());
    rd(4'hF, 32'h0000_0000, '1, "unmapped");
    bus(1'b1, `REG_CTRL, 32'h0000_0F21);
    rd(`REG_CTRL, 32'h0000_0F21, '1, "ctrl");
    setv(16'h2710, 16'h2710 + r, 1'b0, 1'b0);
    rd(`REG_MAG_DIFF, {16'h0000, r}, '1, "mag diff");
    rd(`REG_ANG_DIFF, {16'h0000, a}, '1, "angle diff");
    rd(`REG_FREQ_DIFF, {16'h0000, f}, '1, "freq diff");
    rd(`REG_STATUS, {21'h0_0000, 3'b010, SW_STILL, VS_LIVE_LIVE, COND_OK}, 32'h0000_07FF,
       "status in sync");
    check("match in sync", {31'h0, match_ok_output}, 32'h1);
    setv(16'h2710, 16'h2710 + r, 1'b1, 1'b0);
    check("match blocked", {31'h0, match_ok_output}, 32'h0);
    check("inhibit late block", {31'h0, inhibited_output}, 32'h0);
    setv(16'h2710, 16'h24B8, 1'b1, 1'b0);
    rd(`REG_MAG_DIFF, 32'hFFFF_FDA8, '1, "negative mag diff");
    rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0200, "status too far");
    setv(16'h2710, 16'h2710 + r, 1'b1, 1'b0);
    check("inhibit at match", {31'h0, inhibited_output}, 32'h1);
    check("match inhibited", {31'h0, match_ok_output}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h0000_0821);
    setv(16'h03E8, 16'h03E8, 1'b0, 1'b0);
    rd(`REG_STATUS, {26'h0, VS_DEAD_DEAD, 3'b000}, 32'h0000_0238, "dead not accepted");
    check("inhibit cleared", {31'h0, inhibited_output}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h0000_0121);
    setv(16'h03E8, 16'h03E8, 1'b0, 1'b0);
    rd(`REG_STATUS, 32'h0000_0200, 32'h0000_0238, "dead accepted");
    bus(1'b1, `REG_CTRL, 32'h0000_0F23);
    setv(16'h2710, 16'h2710 + r, 1'b0, 1'b0);
    check("match no start", {31'h0, match_ok_output}, 32'h0);
    setv(16'h2710, 16'h2710 + r, 1'b0, 1'b1);
    check("match started", {31'h0, match_ok_output}, 32'h1);
    bus(1'b1, `REG_BRK_TIME, 32'h0000_FFFF);
    bus(1'b1, `REG_CTRL, 32'h0000_0F25);
    a = a >> 1;
    setv(16'h2710, 16'h2710 + r, 1'b0, 1'b0);
    rd(`REG_STATUS, 32'h0000_0280, 32'h0000_02C0, "status enclosing");
    rd(`REG_ROTATE, 32'h0003_0D40 / 32'(f), '1, "rotation time");
    rd(`REG_CLOSE_EST, (32'(a) * (32'h0003_0D40 / 32'(f))) / 32'h0000_8CA0, '1,
       "closing estimate");
    rd(`REG_PLACE, 32'(a) * 32'h0000_000A, '1, "placement");
    check("close early", closes, 32'h0);
    @(posedge clk_sys);
    while (cycle_tick !== 1'b1) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    check("close at enclosing", closes, 32'h1);
    repeat (2) @(posedge clk_sys);
    close_out();
  end
endmodule : testbench
`default_nettype wire
